// ### pkg/snsw_pkg.sv
// package: constants and carrier types for the sleep/wake controller
`default_nettype none
package snsw_pkg;
   localparam int CLK_HZ = 250_000_000;
   localparam int MS_PER_SEC = 1000;
   localparam int MS_PER_QUARTER = 250;
   localparam int CYC_PER_MS = CLK_HZ / MS_PER_SEC;
   // s-register numbers used as command indices
   localparam logic [7:0] IDX_POLL_TMO = 8'h33;
   localparam logic [7:0] IDX_AWAKE_POLL = 8'h34;
   localparam logic [7:0] IDX_SLEEP_DUR = 8'h35;
   localparam logic [7:0] IDX_STANDBY = 8'h36;
   localparam logic [7:0] IDX_REJOIN = 8'h37;
   localparam logic [7:0] IDX_NONSLEEPY = 8'h38;
   localparam int NSREG = 6;
   localparam logic [7:0] POLL_TMO_RST = 8'h3C;
   localparam logic [7:0] AWAKE_POLL_RST = 8'h64;
   localparam logic [7:0] SLEEP_DUR_RST = 8'h08;
   localparam logic [7:0] STANDBY_RST = 8'h05;
   localparam logic [7:0] REJOIN_RST = 8'h0A;
   localparam logic [7:0] NONSLEEPY_RST = 8'h05;
   localparam int KEY_W = 128;
   localparam int KEY_SLOTS = 4;
   localparam logic [KEY_W-1:0] KEY_RST = {KEY_W{1'b1}};
   localparam logic [1:0] SLOT_LINK = 2'h0;
   localparam logic [1:0] SLOT_NWK_A = 2'h1;
   localparam logic [1:0] SLOT_NWK_B = 2'h2;
   localparam int NCHILD = 4;
   localparam logic [1:0] ESC_LEN = 2'h3;
   localparam logic [7:0] ESC_CHAR = 8'h2B;
   localparam logic SEC_RST = 1'b0;
   localparam logic [4:0] CHAN_RST = 5'h0B;
   localparam int MSW = 18;

   typedef enum logic [2:0] {
      OP_WR_SREG,
      OP_RD_SREG,
      OP_SET_SEC,
      OP_SET_LINK,
      OP_SET_NWK,
      OP_RD_KEY,
      OP_DATA_MODE
   } snsw_op_t;

   typedef struct packed {
      logic valid;
      snsw_op_t op;
      logic [7:0] idx;
      logic [7:0] data;
      logic [KEY_W-1:0] key;
   } snsw_cmd_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } snsw_ser_t;

   typedef struct packed {
      logic valid;
      logic [4:0] chan;
   } snsw_chan_t;

   typedef struct packed {
      logic update;
      logic switch_now;
      logic [KEY_W-1:0] key;
   } snsw_keymsg_t;

   typedef struct packed {
      logic valid;
      logic [KEY_W-1:0] key;
   } snsw_join_t;

   typedef struct packed {
      logic valid;
      logic [1:0] id;
   } snsw_child_t;
endpackage : snsw_pkg
`default_nettype wire

// ### logic/snsw_key_mem.sv
// small key store with a registered read port
`timescale 1ns/10ps
`default_nettype none
module snsw_key_mem (
   input wire logic i_clk, // system clock
   input wire logic i_sys_rst, // sync reset, high
   input wire logic i_we, // write strobe
   input wire logic [1:0] i_waddr, // write slot
   input wire logic [snsw_pkg::KEY_W-1:0] i_wdata, // write key
   input wire logic i_re, // read strobe
   input wire logic [1:0] i_raddr, // read slot
   output logic [snsw_pkg::KEY_W-1:0] o_rdata // read key, next cycle
);
   import snsw_pkg::*;

   logic [KEY_W-1:0] mem_r [KEY_SLOTS];

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         for (int i = 0; i < KEY_SLOTS; i++) begin
            mem_r[i] <= KEY_RST;
         end
      end else if (i_we) begin
         mem_r[i_waddr] <= i_wdata;
      end
   end

   // read returns the old word when read and write hit the same slot
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_rdata <= KEY_RST;
      end else if (i_re) begin
         o_rdata <= mem_r[i_raddr];
      end
   end
endmodule : snsw_key_mem
`default_nettype wire

// ### logic/snsw_sleep_ctrl.sv
// sleep/wake sequencer, parent polling, keys, channel and escape handling
`timescale 1ns/10ps
`default_nettype none
module snsw_sleep_ctrl #(
   parameter int CYC_PER_MS = snsw_pkg::CYC_PER_MS
) (
   input wire logic i_clk, // system clock
   input wire logic i_sys_rst, // sync reset, high
   input wire snsw_pkg::snsw_cmd_t i_cmd, // decoded host command
   input wire logic i_wake_input, // host wake pin
   input wire snsw_pkg::snsw_ser_t i_ser_rx, // host serial byte in
   input wire logic i_ser_tx, // byte sent to host
   input wire logic i_rf_rx, // radio frame received
   input wire logic i_rf_tx, // radio frame sent
   input wire logic i_parent_ack, // parent answered a poll
   input wire snsw_pkg::snsw_chan_t i_chan_msg, // channel change
   input wire snsw_pkg::snsw_keymsg_t i_key_msg, // key broadcast
   input wire snsw_pkg::snsw_join_t i_join, // join key check
   input wire snsw_pkg::snsw_child_t i_child_poll, // child poll
   output logic o_radio_on, // radio powered
   output logic o_poll_req, // poll parent, pulse
   output logic o_rejoin_req, // rejoin network, pulse
   output logic [4:0] o_chan, // operating channel
   output logic o_chan_chg, // channel moved, pulse
   output logic o_sec_en, // network security on
   output logic [1:0] o_nwk_slot, // active network key slot
   output logic o_cmd_mode, // command mode
   output logic o_rx_suspect, // waking byte unreliable
   output logic [7:0] o_sreg_rd, // s-register read data
   output logic o_sreg_rd_vld, // read data valid, pulse
   output logic [snsw_pkg::KEY_W-1:0] o_key_rd, // key read data
   output logic o_key_rd_vld, // key data valid, pulse
   output logic o_join_grant, // join accepted, pulse
   output logic o_join_deny, // join refused, pulse
   output logic [snsw_pkg::NCHILD-1:0] o_child_live // child table
);
   import snsw_pkg::*;

   typedef enum logic {ST_SLEEP, ST_AWAKE} snsw_state_t;

   // one-hot select of the s-register index, shared by reads and writes
   function automatic logic [NSREG-1:0] sreg_sel(input logic [7:0] idx);
      sreg_sel = {idx == IDX_NONSLEEPY, idx == IDX_REJOIN,
                  idx == IDX_STANDBY, idx == IDX_SLEEP_DUR,
                  idx == IDX_AWAKE_POLL, idx == IDX_POLL_TMO};
   endfunction : sreg_sel

   // configuration
   logic [7:0] poll_tmo_r;
   logic [7:0] awake_poll_r;
   logic [7:0] sleep_dur_r;
   logic [7:0] standby_r;
   logic [7:0] rejoin_r;
   logic [7:0] nonsleepy_r;

   // prescalers
   logic [MSW-1:0] cyc_cnt_r;
   logic ms_tick_r;
   logic [9:0] ms_cnt_r;
   logic sec_tick_r;

   snsw_state_t state_r;
   snsw_state_t state_nxt;
   logic [15:0] sleep_cnt_r;
   logic [MSW-1:0] standby_cnt_r;
   logic [7:0] poll_cnt_r;
   logic [MSW-1:0] link_cnt_r;
   logic wake_q_r;
   logic [1:0] esc_cnt_r;
   logic join_pend_r;
   logic [KEY_W-1:0] join_key_r;

   // command decode
   wire cmd_wr = i_cmd.valid && i_cmd.op == OP_WR_SREG;
   wire cmd_rd = i_cmd.valid && i_cmd.op == OP_RD_SREG;
   wire [NSREG-1:0] wr_sel = cmd_wr ? sreg_sel(i_cmd.idx) : '0;
   wire [NSREG-1:0] rd_sel = sreg_sel(i_cmd.idx);
   wire [7:0] rd_mux =
      ({8{rd_sel[0]}} & poll_tmo_r) | ({8{rd_sel[1]}} & awake_poll_r) |
      ({8{rd_sel[2]}} & sleep_dur_r) | ({8{rd_sel[3]}} & standby_r) |
      ({8{rd_sel[4]}} & rejoin_r) | ({8{rd_sel[5]}} & nonsleepy_r);

   // durations in milliseconds
   wire [15:0] sleep_ms = 16'(sleep_dur_r) * 16'(MS_PER_QUARTER);
   wire [MSW-1:0] standby_ms = MSW'(standby_r) * MSW'(MS_PER_SEC);
   wire [MSW-1:0] rejoin_ms = MSW'(rejoin_r) * MSW'(MS_PER_SEC);

   // events
   wire asleep = state_r == ST_SLEEP;
   wire wake_rise = i_wake_input && !wake_q_r;
   wire sleep_exp = asleep && ms_tick_r && sleep_cnt_r <= 16'h0001;
   wire wake_evt = asleep && (sleep_exp || wake_rise || i_ser_rx.valid);
   wire traffic = i_ser_rx.valid || i_ser_tx || i_rf_rx || i_rf_tx;
   wire standby_exp = !asleep && !traffic && ms_tick_r &&
                      standby_cnt_r <= MSW'(1);
   // a poll on the sleep-entry tick would leave with the radio already off
   wire poll_due = !asleep && !standby_exp && ms_tick_r && poll_cnt_r <= 8'h01;
   wire link_lost = !asleep && !i_parent_ack && ms_tick_r &&
                    link_cnt_r + MSW'(1) >= rejoin_ms;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_SLEEP: begin
            if (wake_evt) begin
               state_nxt = ST_AWAKE;
            end
         end
         ST_AWAKE: begin
            if (standby_exp) begin
               state_nxt = ST_SLEEP;
            end
         end
         default: state_nxt = ST_AWAKE;
      endcase
   end

   // key store access: radio key messages take the write port first
   wire upd_wr = i_key_msg.update;
   wire cmd_link = i_cmd.valid && i_cmd.op == OP_SET_LINK;
   wire cmd_nwk = i_cmd.valid && i_cmd.op == OP_SET_NWK;
   wire cmd_key_rd = i_cmd.valid && i_cmd.op == OP_RD_KEY && !i_join.valid;
   wire [1:0] spare_slot = (o_nwk_slot == SLOT_NWK_A) ? SLOT_NWK_B :
                           SLOT_NWK_A;
   wire mem_we = upd_wr || cmd_link || cmd_nwk;
   wire [1:0] mem_waddr = upd_wr ? spare_slot :
                          cmd_link ? SLOT_LINK : o_nwk_slot;
   wire [KEY_W-1:0] mem_wdata = upd_wr ? i_key_msg.key : i_cmd.key;
   wire mem_re = i_join.valid || cmd_key_rd;
   wire [1:0] mem_raddr = i_join.valid ? SLOT_LINK : i_cmd.idx[1:0];
   wire [KEY_W-1:0] mem_rdata;
   wire key_match = mem_rdata == join_key_r;

   snsw_key_mem u_key_mem (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_we(mem_we),
      .i_waddr(mem_waddr),
      .i_wdata(mem_wdata),
      .i_re(mem_re),
      .i_raddr(mem_raddr),
      .o_rdata(mem_rdata)
   );

   assign o_key_rd = mem_rdata;

   // millisecond and second ticks
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || cyc_cnt_r == MSW'(CYC_PER_MS - 1)) begin
         cyc_cnt_r <= '0;
      end else begin
         cyc_cnt_r <= cyc_cnt_r + MSW'(1);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ms_tick_r <= 1'b0;
         sec_tick_r <= 1'b0;
         ms_cnt_r <= '0;
      end else begin
         ms_tick_r <= cyc_cnt_r == MSW'(CYC_PER_MS - 1);
         sec_tick_r <= ms_tick_r && ms_cnt_r == 10'(MS_PER_SEC - 1);
         if (ms_tick_r) begin
            ms_cnt_r <= (ms_cnt_r == 10'(MS_PER_SEC - 1)) ? '0 :
                        ms_cnt_r + 10'h001;
         end
      end
   end

   // configuration registers
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         poll_tmo_r <= POLL_TMO_RST;
         awake_poll_r <= AWAKE_POLL_RST;
         sleep_dur_r <= SLEEP_DUR_RST;
         standby_r <= STANDBY_RST;
         rejoin_r <= REJOIN_RST;
         nonsleepy_r <= NONSLEEPY_RST;
      end else begin
         if (wr_sel[0]) poll_tmo_r <= i_cmd.data;
         if (wr_sel[1]) awake_poll_r <= i_cmd.data;
         if (wr_sel[2]) sleep_dur_r <= i_cmd.data;
         if (wr_sel[3]) standby_r <= i_cmd.data;
         if (wr_sel[4]) rejoin_r <= i_cmd.data;
         // stored for readback only; the sleepy node never polls on it
         if (wr_sel[5]) nonsleepy_r <= i_cmd.data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_sreg_rd <= 8'h00;
         o_sreg_rd_vld <= 1'b0;
      end else begin
         o_sreg_rd_vld <= cmd_rd;
         if (cmd_rd) begin
            o_sreg_rd <= rd_mux;
         end
      end
   end

   // sleep/wake sequencing
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_r <= ST_AWAKE;
         o_radio_on <= 1'b1;
         wake_q_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         o_radio_on <= state_nxt == ST_AWAKE;
         wake_q_r <= i_wake_input;
      end
   end

   // the sleep duration is the time asleep, from sleep entry to the timed wake
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         sleep_cnt_r <= 16'h0000;
      end else if (standby_exp) begin
         sleep_cnt_r <= sleep_ms;
      end else if (asleep && ms_tick_r && sleep_cnt_r != 16'h0000) begin
         sleep_cnt_r <= sleep_cnt_r - 16'h0001;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst || wake_evt || traffic) begin
         standby_cnt_r <= standby_ms;
      end else if (!asleep && ms_tick_r && standby_cnt_r != '0) begin
         standby_cnt_r <= standby_cnt_r - MSW'(1);
      end
   end

   // parent polling runs only while awake and is frozen during sleep
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         poll_cnt_r <= AWAKE_POLL_RST;
         o_poll_req <= 1'b0;
      end else begin
         o_poll_req <= wake_evt || poll_due;
         if (wake_evt || poll_due) begin
            poll_cnt_r <= awake_poll_r;
         end else if (!asleep && ms_tick_r) begin
            poll_cnt_r <= poll_cnt_r - 8'h01;
         end
      end
   end

   // link supervision counts awake time since the last parent answer
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         link_cnt_r <= '0;
         o_rejoin_req <= 1'b0;
      end else begin
         o_rejoin_req <= link_lost;
         if (i_parent_ack || link_lost) begin
            link_cnt_r <= '0;
         end else if (!asleep && ms_tick_r) begin
            link_cnt_r <= link_cnt_r + MSW'(1);
         end
      end
   end

   // the byte that wakes the node is flagged so the host path can drop it
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_rx_suspect <= 1'b0;
      end else begin
         o_rx_suspect <= asleep && i_ser_rx.valid;
      end
   end

   // child table ageing, in whole seconds
   generate
      for (genvar g = 0; g < NCHILD; g++) begin : g_child
         logic [7:0] age_r;
         wire hit = i_child_poll.valid && i_child_poll.id == 2'(g);
         always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
               o_child_live[g] <= 1'b0;
               age_r <= 8'h00;
            end else if (hit) begin
               o_child_live[g] <= 1'b1;
               age_r <= 8'h00;
            end else if (o_child_live[g] && sec_tick_r) begin
               age_r <= age_r + 8'h01;
               if (age_r + 8'h01 >= poll_tmo_r) begin
                  o_child_live[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // security level and channel
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_sec_en <= SEC_RST;
         o_chan <= CHAN_RST;
         o_chan_chg <= 1'b0;
      end else begin
         if (i_cmd.valid && i_cmd.op == OP_SET_SEC) begin
            o_sec_en <= i_cmd.data == 8'h01;
         end
         o_chan_chg <= i_chan_msg.valid;
         if (i_chan_msg.valid) begin
            o_chan <= i_chan_msg.chan;
         end
      end
   end

   // a staged key only goes live on the switch broadcast
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_nwk_slot <= SLOT_NWK_A;
      end else if (i_key_msg.switch_now && !i_key_msg.update) begin
         o_nwk_slot <= spare_slot;
      end
   end

   // join check and key readback
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         join_pend_r <= 1'b0;
         join_key_r <= '0;
         o_join_grant <= 1'b0;
         o_join_deny <= 1'b0;
         o_key_rd_vld <= 1'b0;
      end else begin
         join_pend_r <= i_join.valid;
         if (i_join.valid) begin
            join_key_r <= i_join.key;
         end
         o_join_grant <= join_pend_r && key_match;
         o_join_deny <= join_pend_r && !key_match;
         o_key_rd_vld <= cmd_key_rd;
      end
   end

   // escape detection; no guard time, any other byte restarts the count
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_cmd_mode <= 1'b1;
         esc_cnt_r <= 2'h0;
      end else if (o_cmd_mode) begin
         esc_cnt_r <= 2'h0;
         if (i_cmd.valid && i_cmd.op == OP_DATA_MODE) begin
            o_cmd_mode <= 1'b0;
         end
      end else if (i_ser_rx.valid) begin
         if (i_ser_rx.data != ESC_CHAR) begin
            esc_cnt_r <= 2'h0;
         end else if (esc_cnt_r + 2'h1 == ESC_LEN) begin
            o_cmd_mode <= 1'b1;
            esc_cnt_r <= 2'h0;
         end else begin
            esc_cnt_r <= esc_cnt_r + 2'h1;
         end
      end
   end
endmodule : snsw_sleep_ctrl
`default_nettype wire

// ### verification/snsw_sleep_props.sv
// checker: port-level properties of the sleep/wake controller
`timescale 1ns/10ps
`default_nettype none
module snsw_sleep_props #(
   parameter int CYC_PER_MS = 4
) (
   input wire logic i_clk, // system clock
   input wire logic i_sys_rst, // sync reset, high
   input wire snsw_pkg::snsw_cmd_t i_cmd, // host command
   input wire logic i_wake_input, // wake pin
   input wire snsw_pkg::snsw_ser_t i_ser_rx, // host byte
   input wire snsw_pkg::snsw_chan_t i_chan_msg, // channel message
   input wire snsw_pkg::snsw_keymsg_t i_key_msg, // key broadcast
   input wire snsw_pkg::snsw_join_t i_join, // join check
   input wire logic o_radio_on, // radio powered
   input wire logic o_poll_req, // poll pulse
   input wire logic [4:0] o_chan, // channel
   input wire logic o_chan_chg, // channel moved
   input wire logic [1:0] o_nwk_slot, // active key slot
   input wire logic o_rx_suspect, // waking byte flag
   input wire logic o_sreg_rd_vld, // read valid
   input wire logic o_join_grant, // join accepted
   input wire logic o_join_deny // join refused
);
   import snsw_pkg::*;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   chk_sreg_read: assert property (
      i_cmd.valid && i_cmd.op == OP_RD_SREG |=> o_sreg_rd_vld)
      else $error("register read gave no valid");
   chk_join_answer: assert property (
      i_join.valid |-> ##2 (o_join_grant != o_join_deny))
      else $error("join check gave no single answer");
   chk_chan_move: assert property (
      i_chan_msg.valid |=> o_chan_chg && o_chan == $past(i_chan_msg.chan))
      else $error("channel did not follow message");
   chk_key_switch: assert property (
      i_key_msg.switch_now && !i_key_msg.update
      |=> o_nwk_slot != $past(o_nwk_slot))
      else $error("key switch did not toggle slot");
   chk_key_store: assert property (
      i_key_msg.update |=> $stable(o_nwk_slot))
      else $error("key update changed active slot");
   chk_pin_wake: assert property (
      !o_radio_on && i_wake_input && !$past(i_wake_input)
      |-> ##[1:2] o_radio_on)
      else $error("wake pin did not wake node");
   chk_ser_wake: assert property (
      !o_radio_on && i_ser_rx.valid |-> ##[1:2] o_rx_suspect)
      else $error("serial wake not flagged");
   chk_wake_poll: assert property (
      $rose(o_radio_on) |-> ##[0:2] o_poll_req)
      else $error("no poll after wake");
   chk_quiet_sleep: assert property (
      !o_radio_on |-> !o_poll_req)
      else $error("poll while radio off");
endmodule : snsw_sleep_props
bind snsw_sleep_ctrl snsw_sleep_props #(.CYC_PER_MS(CYC_PER_MS)) u_props (
   .i_clk, .i_sys_rst, .i_cmd, .i_wake_input, .i_ser_rx, .i_chan_msg,
   .i_key_msg, .i_join, .o_radio_on, .o_poll_req, .o_chan, .o_chan_chg,
   .o_nwk_slot, .o_rx_suspect, .o_sreg_rd_vld, .o_join_grant, .o_join_deny
);
`default_nettype wire

// ### verification/snsw_parent_model.sv
// partner: parent router answering the node's polls
`timescale 1ns/10ps
`default_nettype none
module snsw_parent_model (
   input wire logic i_clk, // system clock
   input wire logic i_sys_rst, // sync reset, high
   input wire logic i_poll_req, // poll from the node
   input wire logic i_mute, // stop answering, link broken
   output logic o_ack // answer pulse
);
   int cnt = 0;
   logic slow = 1'b0;
   logic ack_r = 1'b0;
   assign o_ack = ack_r;
   // alternate prompt and slow answers so link supervision sees both
   always @(posedge i_clk) begin
      ack_r <= 1'b0;
      if (i_sys_rst) begin
         cnt <= 0;
      end else if (i_poll_req && !i_mute) begin
         cnt <= slow ? 5 : 1;
         slow <= ~slow;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         ack_r <= (cnt == 1);
      end
   end
endmodule : snsw_parent_model
`default_nettype wire

// ### verification/snsw_sleep_ctrl_bench.sv
// testbench: sleep/wake controller against a behavioural model
`timescale 1ns/10ps
`default_nettype none
module snsw_sleep_ctrl_bench;
   import snsw_pkg::*;
   localparam int CPM = 4;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   snsw_cmd_t i_cmd = '0;
   logic i_wake_input = 1'b0;
   snsw_ser_t i_ser_rx = '0;
   logic i_ser_tx = 1'b0, i_rf_rx = 1'b0, i_rf_tx = 1'b0, mute = 1'b0;
   logic i_parent_ack;
   snsw_chan_t i_chan_msg = '0;
   snsw_keymsg_t i_key_msg = '0;
   snsw_join_t i_join = '0;
   snsw_child_t i_child_poll = '0;
   logic o_radio_on, o_poll_req, o_rejoin_req, o_chan_chg, o_sec_en;
   logic o_cmd_mode, o_rx_suspect, o_sreg_rd_vld, o_key_rd_vld;
   logic o_join_grant, o_join_deny;
   logic [4:0] o_chan, c;
   logic [1:0] o_nwk_slot, m_slot;
   logic [7:0] o_sreg_rd;
   logic [KEY_W-1:0] o_key_rd, k;
   logic [3:0] o_child_live;
   logic [7:0] m_sr [6];
   logic [KEY_W-1:0] m_key [3];
   logic m_mode;
   int error_cnt = 0, num_checks = 0, n, esc;
   initial begin
      forever #2 i_clk = ~i_clk;
   end
   snsw_sleep_ctrl #(.CYC_PER_MS(CPM)) uut (
      .i_clk, .i_sys_rst, .i_cmd, .i_wake_input, .i_ser_rx, .i_ser_tx,
      .i_rf_rx, .i_rf_tx, .i_parent_ack, .i_chan_msg, .i_key_msg, .i_join,
      .i_child_poll, .o_radio_on, .o_poll_req, .o_rejoin_req, .o_chan,
      .o_chan_chg, .o_sec_en, .o_nwk_slot, .o_cmd_mode, .o_rx_suspect,
      .o_sreg_rd, .o_sreg_rd_vld, .o_key_rd, .o_key_rd_vld, .o_join_grant,
      .o_join_deny, .o_child_live
   );
   snsw_parent_model u_parent (.i_clk, .i_sys_rst, .i_poll_req(o_poll_req),
      .i_mute(mute), .o_ack(i_parent_ack));
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [KEY_W-1:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : chk
   task automatic step(input int cy = 1);
      repeat (cy) @(posedge i_clk);
      #1;
   endtask : step
   function automatic logic hit(input int w);
      case (w)
         0: return o_radio_on === 1'b0;
         1: return o_radio_on === 1'b1;
         2: return o_rejoin_req === 1'b1;
         3: return o_child_live === 4'h0;
         default: return o_poll_req === 1'b1;
      endcase
   endfunction : hit
   // every wait is bounded; running out ends the run as a failure
   task automatic wait_on(input int lim, w, output int cy);
      cy = 0;
      while (!hit(w)) begin
         step();
         cy++;
         if (cy > lim) begin
            error_cnt++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, cy, lim);
            test_done();
         end
      end
   endtask : wait_on
   task automatic cmd(input snsw_op_t op, input logic [7:0] idx, d,
                      input logic [KEY_W-1:0] key = '0);
      i_cmd = '{1'b1, op, idx, d, key};
      @(posedge i_clk);
      // dropped at the taking edge so back-to-back calls never write twice
      i_cmd.valid <= 1'b0;
      #1;
   endtask : cmd
   function automatic logic known(input logic [7:0] idx);
      return idx >= IDX_POLL_TMO && idx <= IDX_NONSLEEPY;
   endfunction : known
   task automatic wr_sreg(input logic [7:0] idx, d);
      cmd(OP_WR_SREG, idx, d);
      if (known(idx)) begin
         m_sr[idx-IDX_POLL_TMO] = d;
      end
   endtask : wr_sreg
   task automatic rd_sreg(input logic [7:0] idx);
      cmd(OP_RD_SREG, idx, 8'h00);
      chk(o_sreg_rd_vld, 1'b1);
      chk(o_sreg_rd, known(idx) ? m_sr[idx-IDX_POLL_TMO] : 8'h00);
   endtask : rd_sreg
   task automatic rd_key(input logic [1:0] s);
      cmd(OP_RD_KEY, {6'h00, s}, 8'h00);
      chk(o_key_rd_vld, 1'b1);
      chk(o_key_rd, m_key[s]);
   endtask : rd_key
   task automatic ser_byte(input logic [7:0] b);
      i_ser_rx = '{1'b1, b};
      step();
      i_ser_rx.valid = 1'b0;
      esc = (b == 8'h2B) ? esc + 1 : 0;
      m_mode = m_mode | (esc == 3);
      step();
   endtask : ser_byte
   initial begin
      void'($urandom(32'h8f0921db));
      m_sr = '{8'h3C, 8'h64, 8'h08, 8'h05, 8'h0A, 8'h05};
      m_key = '{default: {KEY_W{1'b1}}};
      m_slot = 2'h1;
      step(20);
      i_sys_rst = 1'b0;
      chk({o_radio_on, o_sec_en, o_cmd_mode, o_chan},
          {3'b101, 5'h0B});
      chk({o_nwk_slot, o_child_live}, {m_slot, 4'h0});
      step();
      for (int i = 0; i < 7; i++) begin
         rd_sreg(IDX_POLL_TMO + i);
      end
      for (int i = 0; i < 6; i++) begin
         wr_sreg(IDX_POLL_TMO + i, 8'($urandom));
         rd_sreg(IDX_POLL_TMO + i);
      end
      wr_sreg(8'h40, 8'h5A);
      rd_sreg(8'h40);
      wr_sreg(IDX_POLL_TMO, 8'h01);
      wr_sreg(IDX_AWAKE_POLL, 8'h03);
      wr_sreg(IDX_SLEEP_DUR, 8'h02);
      wr_sreg(IDX_STANDBY, 8'h05);
      wr_sreg(IDX_REJOIN, 8'h01);
      $display("test registers done");
      foreach (m_sr[i]) begin
         cmd(OP_SET_SEC, 8'h00, 8'(i % 3));
         chk(o_sec_en, (i % 3) == 1);
      end
      $display("test security done");
      k = {$urandom, $urandom, $urandom, $urandom};
      cmd(OP_SET_LINK, 8'h00, 8'h00, k);
      m_key[0] = k;
      rd_key(2'h0);
      i_join = '{1'b1, k};
      step();
      i_join.key = ~k;
      step();
      // the answer to the first key stands one edge after it was taken
      i_join.valid = 1'b0;
      chk({o_join_grant, o_join_deny}, 2'b10);
      step();
      chk({o_join_grant, o_join_deny}, 2'b01);
      k = {$urandom, $urandom, $urandom, $urandom};
      cmd(OP_SET_NWK, 8'h00, 8'h00, k);
      m_key[m_slot] = k;
      rd_key(m_slot);
      k = {$urandom, $urandom, $urandom, $urandom};
      i_key_msg = '{1'b1, 1'b0, k};
      step();
      i_key_msg.update = 1'b0;
      m_key[2'h3 - m_slot] = k;
      step();
      chk(o_nwk_slot, m_slot);
      rd_key(2'h3 - m_slot);
      i_key_msg.switch_now = 1'b1;
      step();
      i_key_msg.switch_now = 1'b0;
      m_slot = 2'h3 - m_slot;
      step();
      chk(o_nwk_slot, m_slot);
      $display("test keys done");
      repeat (3) begin
         c = 5'($urandom);
         i_chan_msg = '{1'b1, c};
         step();
         chk({o_chan_chg, o_chan}, {1'b1, c});
      end
      i_chan_msg.valid = 1'b0;
      cmd(OP_DATA_MODE, 8'h00, 8'h00);
      m_mode = 1'b0;
      esc = 0;
      chk(o_cmd_mode, m_mode);
      foreach (m_sr[i]) begin
         ser_byte(i == 2 ? 8'h41 : 8'h2B);
         chk(o_cmd_mode, m_mode);
      end
      $display("test channel and escape done");
      // the first poll after reset still runs on the reset period of 100 ms
      wait_on(500, 4, n);
      step();
      wait_on(100, 4, n);
      chk(n, 3 * CPM - 1);
      mute = 1'b1;
      i_child_poll = '{1'b1, 2'h2};
      step();
      i_child_poll.valid = 1'b0;
      step();
      chk(o_child_live, 4'h4);
      wait_on(5000, 2, n);
      chk(n inside {[3960:4010]}, 1'b1);
      wait_on(9000, 3, n);
      mute = 1'b0;
      $display("test link and child done");
      wr_sreg(IDX_STANDBY, 8'h01);
      i_rf_rx = 1'b1;
      step();
      i_rf_rx = 1'b0;
      step(2000);
      {i_ser_tx, i_rf_tx} = 2'b11;
      step();
      {i_ser_tx, i_rf_tx} = 2'b00;
      wait_on(6000, 0, n);
      chk(n inside {[3992:4008]}, 1'b1);
      wait_on(3000, 1, n);
      chk(n inside {[1992:2008]}, 1'b1);
      wait_on(6000, 0, n);
      i_wake_input = 1'b1;
      step(2);
      chk(o_radio_on, 1'b1);
      i_wake_input = 1'b0;
      wait_on(6000, 0, n);
      // the waking byte must be flagged in the cycle after its pulse is taken
      i_ser_rx = '{1'b1, 8'h55};
      step();
      i_ser_rx.valid = 1'b0;
      chk({o_radio_on, o_rx_suspect}, 2'b11);
      $display("test sleep and wake done");
      test_done();
   end
endmodule : snsw_sleep_ctrl_bench
`default_nettype wire
